// [rtl/lcb_config_bank.sv]
`timescale 1ns/10ps
module lcb_config_bank (
   input wire logic i_core_clk, // Core clock, 125 MHz
   input wire logic i_arst_n, // Asynchronous reset, active low
   input wire lcb_pkg::lcb_cfg_req_t i_cfg_req, // Config access from front end
   input wire logic i_lock_sw, // Global software lock enable
   input wire logic [2:0] i_lock_select, // Per-device lock select
   input wire logic i_hw_config_lock_n, // Lock pin, active low
   input wire logic i_ser1_tx_busy, // Serial 1 has data to send
   input wire logic i_ser1_bit_tick, // One pulse per serial bit time
   input wire logic i_ir_rx, // Infrared receive pin
   input wire logic i_card_present_n, // Card present pin
   input wire logic i_card_power_on, // Card power request
   output logic [7:0] o_cfg_rdata, // Read data
   output logic o_cfg_rvalid, // Read data valid pulse
   output logic o_cfg_claim, // Read hit in this bank
   output lcb_pkg::lcb_io_cfg_t [2:0] o_io_cfg, // Enable, base, IRQ per device
   output lcb_pkg::lcb_floppy_mode_t o_floppy_mode, // Floppy options
   output lcb_pkg::lcb_serial_mode_t o_serial1_mode, // Serial 1 options
   output logic o_ser1_tx_allow, // Transmitter may send
   output logic o_ser1_rx_allow, // Receiver may accept
   output logic o_ser1_ir_rx, // Infrared receive, active high
   output logic o_card_present, // Card present, active high
   output logic o_card_power_switch_n, // Card power switch pin
   output lcb_pkg::lcb_card_clk_cfg_t o_card_clock // Card clock select
);

   typedef enum {ST_RX, ST_TX_WAIT, ST_TX, ST_RX_WAIT} lcb_turn_state_t;

   function automatic logic hits(input lcb_pkg::lcb_cfg_req_t req,
                                 input logic [7:0] logical_device_number,
                                 input logic [7:0] idx);
      hits = (req.logical_device_number == logical_device_number) && (req.index == idx);
   endfunction

   logic [2:0][7:0] activate;
   logic [2:0][7:0] base_high;
   logic [2:0][7:0] base_low;
   logic [2:0][7:0] irq_sel;
   logic [7:0] floppy_dma;
   logic [7:0] floppy_one;
   logic [7:0] floppy_two;
   logic [7:0] serial_one;
   logic [7:0] serial_two;
   logic [7:0] card_clock;
   logic [7:0] card_div;
   logic [7:0] test_a;
   logic [7:0] test_b;
   logic [2:0][2:0] pin_sync;
   logic [2:0] pin_filt;
   lcb_turn_state_t turn_state;
   lcb_turn_state_t next_turn_state;
   logic [5:0] turn_count;
   logic [5:0] next_turn_count;
   logic [7:0] next_rdata;
   logic next_claim;

   wire [2:0] pin_raw = {i_card_present_n, i_ir_rx, i_hw_config_lock_n};
   wire hw_lock_n = pin_filt[0];
   wire ir_rx_pin = pin_filt[1];
   wire card_present_pin = pin_filt[2];
   wire lock_on = i_lock_sw | ~hw_lock_n;
   wire [2:0] locked = {3{lock_on}} & i_lock_select;
   wire wr = i_cfg_req.wr;
   wire [7:0] wdata = i_cfg_req.wdata;
   wire floppy_ok = wr & ~locked[0];
   wire serial1_ok = wr & ~locked[1];
   wire [2:0] mode_bits = serial_one[6:4];
   wire ir_mode = (mode_bits == lcb_pkg::SER_MODE_SLOW_IR) ||
                  (mode_bits == lcb_pkg::SER_MODE_ASK_IR);
   wire card_mode = (mode_bits == lcb_pkg::SER_MODE_CARD);
   wire no_tx_delay = serial_two[7];
   wire no_rx_delay = serial_two[6];
   wire single_mask = serial_two[5];
   wire half_duplex = serial_two[4];
   wire ir_active_low = serial_two[3];
   wire card_pfet_high = card_clock[2];
   wire card_present_high = card_div[7];
   wire turn_done = i_ser1_bit_tick && (turn_count == lcb_pkg::TURN_LAST);

   // Pins pass three flops; the filtered level moves only when stages 2 and 3 agree
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_pin
         always_ff @(posedge i_core_clk or negedge i_arst_n)
         begin
            if (!i_arst_n)
            begin
               pin_sync[g] <= (g == 1) ? 3'h0 : 3'h7; // Idle level, so no false lock
               pin_filt[g] <= (g == 1) ? 1'b0 : 1'b1;
            end
            else
            begin
               pin_sync[g] <= {pin_sync[g][1:0], pin_raw[g]};
               if (pin_sync[g][1] == pin_sync[g][2])
                  pin_filt[g] <= pin_sync[g][2];
            end
         end
      end

      // Registers common to all three logical devices
      for (g = 0; g < 3; g++)
      begin : g_dev
         wire dev_ok = wr & ~locked[g];
         wire [7:0] dev_ldn = 8'(g);
         always_ff @(posedge i_core_clk or negedge i_arst_n)
         begin
            if (!i_arst_n)
            begin
               activate[g] <= lcb_pkg::RST_ZERO;
               base_high[g] <= lcb_pkg::RST_BASE_HIGH[g];
               base_low[g] <= lcb_pkg::RST_BASE_LOW[g];
               irq_sel[g] <= lcb_pkg::RST_IRQ[g];
            end
            else
            begin
               if (dev_ok && hits(i_cfg_req, dev_ldn, lcb_pkg::IDX_ACTIVATE))
                  activate[g] <= wdata & lcb_pkg::MASK_ACTIVATE;
               if (dev_ok && hits(i_cfg_req, dev_ldn, lcb_pkg::IDX_BASE_HIGH))
                  base_high[g] <= wdata & lcb_pkg::MASK_BASE_HIGH;
               if (dev_ok && hits(i_cfg_req, dev_ldn, lcb_pkg::IDX_BASE_LOW))
                  base_low[g] <= wdata & lcb_pkg::MASK_BASE_LOW;
               if (dev_ok && hits(i_cfg_req, dev_ldn, lcb_pkg::IDX_IRQ_SEL))
                  irq_sel[g] <= wdata & lcb_pkg::MASK_IRQ;
            end
         end
      end
   endgenerate

   // Floppy special registers
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         floppy_dma <= lcb_pkg::RST_DMA;
         floppy_one <= lcb_pkg::RST_ZERO;
         floppy_two <= lcb_pkg::RST_ZERO;
      end
      else
      begin
         if (floppy_ok && hits(i_cfg_req, lcb_pkg::LDN_FLOPPY, lcb_pkg::IDX_DMA_SEL))
            floppy_dma <= wdata & lcb_pkg::MASK_DMA;
         // Write protect stays writable under lock so media can still be guarded
         if (wr && hits(i_cfg_req, lcb_pkg::LDN_FLOPPY, lcb_pkg::IDX_SPECIAL_ONE))
         begin
            if (!locked[0])
               floppy_one <= wdata & lcb_pkg::MASK_FLOPPY_ONE;
            else
               floppy_one[0] <= wdata[0];
         end
         if (floppy_ok && hits(i_cfg_req, lcb_pkg::LDN_FLOPPY, lcb_pkg::IDX_SPECIAL_TWO))
            floppy_two <= wdata & lcb_pkg::MASK_FLOPPY_TWO;
      end
   end

   // Serial 1 special registers
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         serial_one <= lcb_pkg::RST_ZERO;
         serial_two <= lcb_pkg::RST_SERIAL_TWO;
         card_clock <= lcb_pkg::RST_ZERO;
         card_div <= lcb_pkg::RST_CARD_DIV;
      end
      else
      begin
         if (serial1_ok && hits(i_cfg_req, lcb_pkg::LDN_SERIAL1, lcb_pkg::IDX_SPECIAL_ONE))
            serial_one <= wdata & lcb_pkg::MASK_SERIAL_ONE;
         if (serial1_ok && hits(i_cfg_req, lcb_pkg::LDN_SERIAL1, lcb_pkg::IDX_SPECIAL_TWO))
            serial_two <= wdata & lcb_pkg::MASK_SERIAL_TWO;
         if (serial1_ok && hits(i_cfg_req, lcb_pkg::LDN_SERIAL1, lcb_pkg::IDX_CARD_CLOCK))
            card_clock <= wdata & lcb_pkg::MASK_CARD_CLOCK;
         if (serial1_ok && hits(i_cfg_req, lcb_pkg::LDN_SERIAL1, lcb_pkg::IDX_CARD_DIV))
            card_div <= wdata & lcb_pkg::MASK_CARD_DIV;
      end
   end

   // Test registers answer in every logical device and keep what is written
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         test_a <= lcb_pkg::RST_ZERO;
         test_b <= lcb_pkg::RST_ZERO;
      end
      else
      begin
         if (wr && i_cfg_req.index == lcb_pkg::IDX_TEST_A)
            test_a <= wdata;
         if (wr && i_cfg_req.index == lcb_pkg::IDX_TEST_B)
            test_b <= wdata;
      end
   end

   // Read mux; unmapped indices read 00h and do not claim the cycle
   always_comb
   begin
      next_rdata = 8'h00;
      next_claim = 1'b1;
      if (i_cfg_req.index == lcb_pkg::IDX_TEST_A)
         next_rdata = test_a;
      else if (i_cfg_req.index == lcb_pkg::IDX_TEST_B)
         next_rdata = test_b;
      else if (i_cfg_req.logical_device_number > lcb_pkg::LDN_SERIAL2)
         next_claim = 1'b0;
      else
      begin
         unique case (i_cfg_req.index)
            lcb_pkg::IDX_ACTIVATE: next_rdata = activate[i_cfg_req.logical_device_number[1:0]];
            lcb_pkg::IDX_BASE_HIGH: next_rdata = base_high[i_cfg_req.logical_device_number[1:0]];
            lcb_pkg::IDX_BASE_LOW: next_rdata = base_low[i_cfg_req.logical_device_number[1:0]];
            lcb_pkg::IDX_IRQ_SEL: next_rdata = irq_sel[i_cfg_req.logical_device_number[1:0]];
            lcb_pkg::IDX_DMA_SEL:
            begin
               next_claim = (i_cfg_req.logical_device_number == lcb_pkg::LDN_FLOPPY);
               next_rdata = next_claim ? floppy_dma : 8'h00;
            end
            lcb_pkg::IDX_SPECIAL_ONE:
            begin
               next_claim = (i_cfg_req.logical_device_number != lcb_pkg::LDN_SERIAL2);
               next_rdata = (i_cfg_req.logical_device_number == lcb_pkg::LDN_FLOPPY) ? floppy_one :
                            (i_cfg_req.logical_device_number == lcb_pkg::LDN_SERIAL1) ? serial_one : 8'h00;
            end
            lcb_pkg::IDX_SPECIAL_TWO:
            begin
               next_claim = (i_cfg_req.logical_device_number != lcb_pkg::LDN_SERIAL2);
               next_rdata = (i_cfg_req.logical_device_number == lcb_pkg::LDN_FLOPPY) ? floppy_two :
                            (i_cfg_req.logical_device_number == lcb_pkg::LDN_SERIAL1) ? serial_two : 8'h00;
            end
            lcb_pkg::IDX_CARD_CLOCK:
            begin
               next_claim = (i_cfg_req.logical_device_number == lcb_pkg::LDN_SERIAL1);
               next_rdata = next_claim ? card_clock : 8'h00;
            end
            lcb_pkg::IDX_CARD_DIV:
            begin
               next_claim = (i_cfg_req.logical_device_number == lcb_pkg::LDN_SERIAL1);
               next_rdata = next_claim ? card_div : 8'h00;
            end
            default: next_claim = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_cfg_rdata <= 8'h00;
         o_cfg_rvalid <= 1'b0;
         o_cfg_claim <= 1'b0;
      end
      else
      begin
         o_cfg_rvalid <= i_cfg_req.rd;
         o_cfg_rdata <= i_cfg_req.rd ? next_rdata : 8'h00;
         o_cfg_claim <= i_cfg_req.rd & next_claim;
      end
   end

   // Infrared turnaround; outside infrared modes the port stays in ST_RX
   always_comb
   begin
      next_turn_state = turn_state;
      next_turn_count = turn_count;
      if (!ir_mode)
      begin
         next_turn_state = ST_RX;
         next_turn_count = 6'h00;
      end
      else
      begin
         unique case (turn_state)
            ST_RX:
               if (i_ser1_tx_busy)
               begin
                  next_turn_state = no_tx_delay ? ST_TX : ST_TX_WAIT;
                  next_turn_count = 6'h00;
               end
            ST_TX_WAIT:
               if (turn_done)
                  next_turn_state = ST_TX;
               else if (i_ser1_bit_tick)
                  next_turn_count = turn_count + 6'h01;
            ST_TX:
               if (!i_ser1_tx_busy)
               begin
                  next_turn_state = no_rx_delay ? ST_RX : ST_RX_WAIT;
                  next_turn_count = 6'h00;
               end
            ST_RX_WAIT:
               if (turn_done)
                  next_turn_state = ST_RX;
               else if (i_ser1_bit_tick)
                  next_turn_count = turn_count + 6'h01;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         turn_state <= ST_RX;
         turn_count <= 6'h00;
      end
      else
      begin
         turn_state <= next_turn_state;
         turn_count <= next_turn_count;
      end
   end

   // Port-side outputs, all registered
   wire next_tx_allow = !ir_mode || (turn_state == ST_TX);
   wire rx_turn_ok = !ir_mode || (turn_state == ST_RX) ||
                     (!half_duplex && turn_state == ST_TX);
   wire next_rx_allow = rx_turn_ok && !(single_mask && i_ser1_tx_busy);

   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_ser1_tx_allow <= 1'b1;
         o_ser1_rx_allow <= 1'b1;
         o_ser1_ir_rx <= 1'b0;
         o_card_present <= 1'b0;
         o_card_power_switch_n <= 1'b1;
         o_card_clock <= '0;
      end
      else
      begin
         o_ser1_tx_allow <= next_tx_allow;
         o_ser1_rx_allow <= next_rx_allow;
         o_ser1_ir_rx <= ir_rx_pin ^ ir_active_low;
         // Card present, power switch and clock select are held idle outside card mode; the divisor always passes
         o_card_present <= card_mode & (card_present_pin ^ ~card_present_high);
         o_card_power_switch_n <= card_mode ?
            ((i_card_power_on ^ ~card_pfet_high)) : ~card_pfet_high;
         o_card_clock.clock_sel <= card_mode ? card_clock[1:0] : 2'h0;
         o_card_clock.divisor <= card_div[6:0];
      end
   end

   // Configuration outputs
   generate
      for (g = 0; g < 3; g++)
      begin : g_out
         always_ff @(posedge i_core_clk or negedge i_arst_n)
         begin
            if (!i_arst_n)
               o_io_cfg[g] <= '0;
            else
            begin
               o_io_cfg[g].enable <= activate[g][0];
               o_io_cfg[g].base <= {4'h0, base_high[g][3:0], base_low[g][7:3], 3'h0};
               o_io_cfg[g].irq <= irq_sel[g][3:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_floppy_mode <= '0;
         o_serial1_mode <= '0;
      end
      else
      begin
         o_floppy_mode.dma <= floppy_dma[2:0];
         o_floppy_mode.irq_share <= floppy_one[3];
         o_floppy_mode.swap_drives <= floppy_one[2];
         o_floppy_mode.three_mode <= floppy_one[1];
         o_floppy_mode.write_protect <= floppy_one[0];
         o_floppy_mode.rate_table_b <= floppy_two[3:2];
         o_floppy_mode.rate_table_a <= floppy_two[1:0];
         o_serial1_mode.mode <= mode_bits;
         o_serial1_mode.clock_src <= serial_one[2:1];
         o_serial1_mode.irq_share <= serial_one[0];
         o_serial1_mode.half_duplex <= half_duplex;
      end
   end

endmodule // lcb_config_bank

// [rtl/lcb_pkg.sv]
// What this block does
// - Index 30h bit 0 enables the function; other bits reserved; resets 00h.
// - Index 60h bits 3-0 give base bits 11:8; bits 7-4 read zero.
// - Index 61h bits 7-3 give base bits 7:3; bits 2-0 read zero.
// - Base pair resets to 03/F0 floppy, 03/F8 serial 1, 02/F8 serial 2.
// - Index 70h bits 3-0 pick the IRQ; resets 06h, 04h, 03h.
// - Floppy index 74h bits 2-0 pick the DMA channel; resets 02h.
// - Floppy F0h bit 3 shares the IRQ, bit 2 swaps drives A and B.
// - Floppy F0h bit 1 picks three-mode, bit 0 forces write protect.
// - Floppy F1h bits 3-2 rate table B, bits 1-0 table A; resets zero.
// - Serial 1 F0h bits 6-4 pick standard, infrared, amplitude-shift or card mode.
// - Serial 1 F0h bits 2-1 pick baud clock; bit 0 shares the IRQ.
// - Infrared receive-to-transmit waits 40 bit times unless F1h bit 7 is set.
// - Infrared transmit-to-receive waits 40 bit times unless F1h bit 6 is set.
// - F1h bit 5 masks the receiver while the port transmits.
// - F1h bit 4 half duplex, bit 3 inverts infrared receive; resets 50h.
// - F2h bits 1-0 and F3h bit 7 act only in smart card reader mode; F2h bit 2 sets the idle power switch level and the F3h divisor drives out in every mode.
// - F2h bits 1-0 pick card clock; bit 2 sets power switch polarity.
// - F3h bit 7 sets card-present polarity, bits 6-0 the divisor; resets 7Fh.
// - Locked floppy registers become read-only except the write protect bit.
package lcb_pkg;
   localparam logic [7:0] LDN_FLOPPY = 8'h00;
   localparam logic [7:0] LDN_SERIAL1 = 8'h01;
   localparam logic [7:0] LDN_SERIAL2 = 8'h02;
   localparam logic [7:0] IDX_TEST_A = 8'h2E;
   localparam logic [7:0] IDX_TEST_B = 8'h2F;
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
   localparam logic [7:0] IDX_BASE_LOW = 8'h61;
   localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
   localparam logic [7:0] IDX_DMA_SEL = 8'h74;
   localparam logic [7:0] IDX_SPECIAL_ONE = 8'hF0;
   localparam logic [7:0] IDX_SPECIAL_TWO = 8'hF1;
   localparam logic [7:0] IDX_CARD_CLOCK = 8'hF2;
   localparam logic [7:0] IDX_CARD_DIV = 8'hF3;
   localparam logic [7:0] MASK_ACTIVATE = 8'h01;
   localparam logic [7:0] MASK_BASE_HIGH = 8'h0F;
   localparam logic [7:0] MASK_BASE_LOW = 8'hF8;
   localparam logic [7:0] MASK_IRQ = 8'h0F;
   localparam logic [7:0] MASK_DMA = 8'h07;
   localparam logic [7:0] MASK_FLOPPY_ONE = 8'h0F;
   localparam logic [7:0] MASK_FLOPPY_TWO = 8'h0F;
   localparam logic [7:0] MASK_SERIAL_ONE = 8'h77;
   localparam logic [7:0] MASK_SERIAL_TWO = 8'hF8;
   localparam logic [7:0] MASK_CARD_CLOCK = 8'h07;
   localparam logic [7:0] MASK_CARD_DIV = 8'hFF;
   localparam logic [7:0] MASK_WRITE_PROTECT = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_DMA = 8'h02;
   localparam logic [7:0] RST_SERIAL_TWO = 8'h50;
   localparam logic [7:0] RST_CARD_DIV = 8'h7F;
   // Indexed by logical device: [0] floppy, [1] serial 1, [2] serial 2
   localparam logic [0:2][7:0] RST_BASE_HIGH = {8'h03, 8'h03, 8'h02};
   localparam logic [0:2][7:0] RST_BASE_LOW = {8'hF0, 8'hF8, 8'hF8};
   localparam logic [0:2][7:0] RST_IRQ = {8'h06, 8'h04, 8'h03};
   localparam int unsigned TURN_BITS = 40;
   localparam logic [5:0] TURN_LAST = 6'(TURN_BITS - 1);

   typedef enum logic [2:0] {
      SER_MODE_STANDARD = 3'h0,
      SER_MODE_SLOW_IR = 3'h1,
      SER_MODE_ASK_IR = 3'h2,
      SER_MODE_CARD = 3'h4
   } lcb_ser_mode_t;

   typedef enum logic [1:0] {
      CARD_CLK_STOP = 2'h0,
      CARD_CLK_3M5 = 2'h1,
      CARD_CLK_7M1 = 2'h2,
      CARD_CLK_DIV96 = 2'h3
   } lcb_card_clk_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] logical_device_number;
      logic [7:0] index;
      logic [7:0] wdata;
   } lcb_cfg_req_t;

   typedef struct packed {
      logic enable;
      logic [15:0] base;
      logic [3:0] irq;
   } lcb_io_cfg_t;

   typedef struct packed {
      logic [2:0] dma;
      logic irq_share;
      logic swap_drives;
      logic three_mode;
      logic write_protect;
      logic [1:0] rate_table_b;
      logic [1:0] rate_table_a;
   } lcb_floppy_mode_t;

   typedef struct packed {
      logic [2:0] mode;
      logic [1:0] clock_src;
      logic irq_share;
      logic half_duplex;
   } lcb_serial_mode_t;

   typedef struct packed {
      logic [1:0] clock_sel;
      logic [6:0] divisor;
   } lcb_card_clk_cfg_t;
endpackage

// [testbench/lcb_config_bank_chk.sv]
`timescale 1ns/10ps
module lcb_config_bank_chk (
   input wire logic i_core_clk, // Core clock
   input wire logic i_arst_n, // Reset, active low
   input wire lcb_pkg::lcb_cfg_req_t i_cfg_req, // Config access
   input wire logic [7:0] o_cfg_rdata, // Read data
   input wire logic o_cfg_rvalid, // Read valid
   input wire lcb_pkg::lcb_io_cfg_t [2:0] o_io_cfg, // Per device config
   input wire lcb_pkg::lcb_serial_mode_t o_serial1_mode, // Serial 1 options
   input wire lcb_pkg::lcb_card_clk_cfg_t o_card_clock // Card clock select
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);
   sequence s_rd_at(logic [7:0] idx);
      i_cfg_req.rd && i_cfg_req.index == idx;
   endsequence
   a_read_answer: assert property (i_cfg_req.rd |=> o_cfg_rvalid)
      else $error("read not answered one cycle later");
   a_no_stray_valid: assert property (!i_cfg_req.rd |=> !o_cfg_rvalid)
      else $error("read valid without a read");
   a_activate_reserved: assert property (s_rd_at(lcb_pkg::IDX_ACTIVATE) |=> o_cfg_rdata[7:1] == 7'h00)
      else $error("activate reserved bits not zero");
   a_base_high_fixed: assert property (s_rd_at(lcb_pkg::IDX_BASE_HIGH) |=> o_cfg_rdata[7:4] == 4'h0)
      else $error("base high upper nibble not zero");
   a_base_low_aligned: assert property (s_rd_at(lcb_pkg::IDX_BASE_LOW) |=> o_cfg_rdata[2:0] == 3'h0)
      else $error("base low bits 2-0 not zero");
   a_irq_upper_zero: assert property (s_rd_at(lcb_pkg::IDX_IRQ_SEL) |=> o_cfg_rdata[7:4] == 4'h0)
      else $error("irq select upper nibble not zero");
   a_dma_upper_zero: assert property (s_rd_at(lcb_pkg::IDX_DMA_SEL) |=> o_cfg_rdata[7:3] == 5'h00)
      else $error("dma select upper bits not zero");
   a_io_base_shape: assert property ((o_io_cfg[0].base[15:12] | o_io_cfg[1].base[15:12]
      | o_io_cfg[2].base[15:12]) == 4'h0 && (o_io_cfg[0].base[2:0] | o_io_cfg[1].base[2:0]
      | o_io_cfg[2].base[2:0]) == 3'h0)
      else $error("decoded base not eight byte aligned below 1000h");
   a_card_sel_gated: assert property ((o_serial1_mode.mode != lcb_pkg::SER_MODE_CARD) [*2]
      |-> o_card_clock.clock_sel == 2'h0)
      else $error("card clock selected outside card mode");
endmodule // lcb_config_bank_chk
bind lcb_config_bank lcb_config_bank_chk chk_u (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
   .i_cfg_req(i_cfg_req), .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
   .o_io_cfg(o_io_cfg), .o_serial1_mode(o_serial1_mode), .o_card_clock(o_card_clock));

// [testbench/lcb_host_model.sv]
`timescale 1ns/10ps
module lcb_host_model (
   input wire logic i_core_clk, // Core clock
   input wire logic [7:0] i_rdata, // Read data
   input wire logic i_rvalid, // Read data valid
   input wire logic i_claim, // Read hit
   output lcb_pkg::lcb_cfg_req_t o_req // Config request
);
   initial o_req = '0;
   // Released fields carry inverted values so a stale copy is never mistaken for live data
   // Test indices are only read here, never written with nonzero data
   task automatic wr(input logic [7:0] logical_device_number, input logic [7:0] idx, input logic [7:0] data);
      @(negedge i_core_clk);
      o_req = '{wr: 1'b1, rd: 1'b0, logical_device_number: logical_device_number, index: idx, wdata: data};
      @(negedge i_core_clk);
      o_req = '{wr: 1'b0, rd: 1'b0, logical_device_number: ~logical_device_number, index: ~idx, wdata: ~data};
   endtask
   task automatic rd(input logic [7:0] logical_device_number, input logic [7:0] idx, output logic [7:0] data,
                     output logic claim, output logic valid);
      @(negedge i_core_clk);
      o_req = '{wr: 1'b0, rd: 1'b1, logical_device_number: logical_device_number, index: idx, wdata: 8'hA5};
      @(negedge i_core_clk);
      o_req = '{wr: 1'b0, rd: 1'b0, logical_device_number: ~logical_device_number, index: ~idx, wdata: 8'h5A};
      data = i_rdata;
      claim = i_claim;
      valid = i_rvalid;
   endtask
endmodule // lcb_host_model

// [testbench/lcb_config_bank_test.sv]
`timescale 1ns/10ps
module lcb_config_bank_test;
   logic clk, rst_n, lock_sw, busy, tick, rvalid, claim, tx_allow, rx_allow;
   logic got_claim, got_valid;
   logic [2:0] lock_sel;
   logic [7:0] rdata, got;
   lcb_pkg::lcb_cfg_req_t req;
   lcb_pkg::lcb_io_cfg_t [2:0] io_cfg;
   lcb_pkg::lcb_serial_mode_t ser_mode;
   lcb_pkg::lcb_card_clk_cfg_t card_clk;
   lcb_pkg::lcb_floppy_mode_t fl_mode;
   logic ir, pwr, ir_out, pres, pfet_n;
   int err_total, checks;
   // Each entry: logical device, index, reset value, writable mask
   localparam logic [31:0] TBL [19] = '{
      32'h0030_0001, 32'h0060_030F, 32'h0061_F0F8, 32'h0070_060F, 32'h0074_0207,
      32'h00F0_000F, 32'h00F1_000F, 32'h0130_0001, 32'h0160_030F, 32'h0161_F8F8,
      32'h0170_040F, 32'h01F0_0077, 32'h01F1_50F8, 32'h01F2_0007, 32'h01F3_7FFF,
      32'h0230_0001, 32'h0260_020F, 32'h0261_F8F8, 32'h0270_030F};
   lcb_host_model host_u (.i_core_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
      .i_claim(claim), .o_req(req));
   lcb_config_bank dut_u (.i_core_clk(clk), .i_arst_n(rst_n), .i_cfg_req(req),
      .i_lock_sw(lock_sw), .i_lock_select(lock_sel), .i_hw_config_lock_n(1'b1),
      .i_ser1_tx_busy(busy), .i_ser1_bit_tick(tick), .i_ir_rx(ir),
      .i_card_present_n(1'b1), .i_card_power_on(pwr), .o_cfg_rdata(rdata),
      .o_cfg_rvalid(rvalid), .o_cfg_claim(claim), .o_io_cfg(io_cfg), .o_floppy_mode(fl_mode),
      .o_serial1_mode(ser_mode), .o_ser1_tx_allow(tx_allow), .o_ser1_rx_allow(rx_allow),
      .o_ser1_ir_rx(ir_out), .o_card_present(pres), .o_card_power_switch_n(pfet_n),
      .o_card_clock(card_clk));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
      checks++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         err_total++;
      end
   endtask
   task automatic rd_chk(input logic [7:0] logical_device_number, input logic [7:0] idx, input logic [7:0] exp);
      host_u.rd(logical_device_number, idx, got, got_claim, got_valid);
      chk("read valid", 16'h0001, {15'h0, got_valid});
      chk($sformatf("read %h/%h", logical_device_number, idx), {8'h00, exp}, {8'h00, got});
   endtask
   // Bit ticks every other cycle, then settle time for the registered outputs
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(negedge clk);
         tick = 1'b1;
         @(negedge clk);
         tick = 1'b0;
      end
      repeat (3) @(negedge clk);
   endtask
   initial
   begin
      repeat (100000) @(posedge clk);
      err_total++;
      wrap_up();
   end
   initial
   begin
      err_total = 0;
      checks = 0;
      rst_n = 1'b0;
      lock_sw = 1'b0;
      lock_sel = 3'h0;
      busy = 1'b0;
      tick = 1'b0;
      ir = 1'b1;
      pwr = 1'b0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      foreach (TBL[k])
      begin
         rd_chk(TBL[k][31:24], TBL[k][23:16], TBL[k][15:8]);
         host_u.wr(TBL[k][31:24], TBL[k][23:16], 8'hFF);
         rd_chk(TBL[k][31:24], TBL[k][23:16], TBL[k][7:0]);
      end
      rd_chk(8'h00, 8'hF2, 8'h00);
      chk("unmapped claim", 16'h0000, {15'h0, got_claim});
      rd_chk(8'h01, 8'h2E, 8'h00);
      repeat (2) @(negedge clk);
      chk("floppy base", 16'h0FF8, io_cfg[0].base);
      chk("floppy enable", 16'h0001, {15'h0, io_cfg[0].enable});
      chk("serial2 irq", 16'h000F, {12'h0, io_cfg[2].irq});
      chk("floppy mode", 16'h07FF, {5'h0, fl_mode});
      chk("ir rx low", 16'h0000, {15'h0, ir_out});
      lock_sw = 1'b1;
      lock_sel = 3'h1;
      host_u.wr(8'h00, 8'h74, 8'h00);
      rd_chk(8'h00, 8'h74, 8'h07);
      host_u.wr(8'h00, 8'hF0, 8'h00);
      rd_chk(8'h00, 8'hF0, 8'h0E);
      chk("floppy locked", 16'h07EF, {5'h0, fl_mode});
      lock_sw = 1'b0;
      host_u.wr(8'h01, 8'hF0, 8'h10);
      host_u.wr(8'h01, 8'hF1, 8'h10);
      repeat (2) @(negedge clk);
      busy = 1'b1;
      ticks(39);
      chk("tx allow early", 16'h0000, {15'h0, tx_allow});
      ticks(1);
      chk("tx allow", 16'h0001, {15'h0, tx_allow});
      chk("rx in half duplex", 16'h0000, {15'h0, rx_allow});
      busy = 1'b0;
      ticks(39);
      chk("rx allow early", 16'h0000, {15'h0, rx_allow});
      ticks(1);
      chk("rx allow", 16'h0001, {15'h0, rx_allow});
      host_u.wr(8'h01, 8'hF1, 8'hD0);
      repeat (2) @(negedge clk);
      busy = 1'b1;
      repeat (3) @(negedge clk);
      chk("tx no delay", 16'h0001, {15'h0, tx_allow});
      busy = 1'b0;
      repeat (3) @(negedge clk);
      chk("rx no delay", 16'h0001, {15'h0, rx_allow});
      chk("ir rx high", 16'h0001, {15'h0, ir_out});
      host_u.wr(8'h01, 8'hF2, 8'h03);
      host_u.wr(8'h01, 8'hF3, 8'h85);
      repeat (2) @(negedge clk);
      chk("card clock off", 16'h0000, {14'h0, card_clk.clock_sel});
      chk("card present off", 16'h0000, {15'h0, pres});
      pwr = 1'b1;
      host_u.wr(8'h01, 8'hF0, 8'h43);
      repeat (2) @(negedge clk);
      chk("card clock", 16'h0003, {14'h0, card_clk.clock_sel});
      chk("card divisor", 16'h0005, {9'h0, card_clk.divisor});
      chk("serial mode", 16'h0047, {9'h0, ser_mode});
      chk("card present", 16'h0001, {15'h0, pres});
      chk("card power", 16'h0000, {15'h0, pfet_n});
      host_u.wr(8'h01, 8'hF1, 8'h30);
      busy = 1'b1;
      repeat (3) @(negedge clk);
      chk("rx masked", 16'h0000, {15'h0, rx_allow});
      wrap_up();
   end
endmodule // lcb_config_bank_test
